// file: rtl/cac_ctrl.sv
// Purpose: Control, status and mode registers of the two-counter array
// Assumes: Single-cycle SFR write and read strobes from the core on clk_sys_i
// Notes: Read data appears one cycle after the read strobe and holds until the next read
// Summary of operation
// - Control bit 6 runs or holds the second counter; only software changes it.
// - Control bit 5 with second overflow flag set raises the interrupt request.
// - Control bit 4 set stops the counter while the CPU is idle.
// - Width select bit: 0 chooses 16-bit PWM, 1 chooses 10-bit PWM.
// - Clock select 00 prescaler, 01 timer 0 overflow, 10 external pin, max fosc/4.
// - Overflow flags at status bits 7 and 3 set by hardware or software, software clears.
// - Six module flags set by match or capture; only software write clears.
// - All eight interrupt sources are ORed into one CPU request.
// - Six mode registers reset to 00h with the documented field layout.
// - Zero mode is no operation; compare and match give timer, plus toggle gives toggle.
// - Compare enable with PWM select 01, 10, 11 gives the three PWM modes.
// - Falling, rising or both capture bits select 16-bit capture on those edges.
// - Low compare byte write clears compare enable; high byte write sets it.
`timescale 1ns/1ns
`default_nettype none
module cac_ctrl
  import cac_pkg::*;
#(
  parameter int NUM_MODULES = NUM_MOD
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic cpu_idle_i,
  input wire logic first_overflow_irq_enable_i,
  input wire logic first_overflow_event_i,
  input wire logic second_overflow_event_i,
  input wire logic [NUM_MODULES-1:0] module_event_i,
  input wire logic prescaler_tick_i,
  input wire logic timer0_overflow_i,
  input wire logic ext_clock_pin_i,
  output logic counter_run_o,
  output logic counter_advance_o,
  output logic counter_tick_o,
  output logic pwm_width_select_o,
  output logic [1:0] clock_select_o,
  output logic [NUM_MODULES-1:0] compare_enable_o,
  output logic [NUM_MODULES-1:0] module_irq_enable_o,
  output cac_func_t module_func_o [NUM_MODULES],
  output logic [15:0] compare_value_o [NUM_MODULES],
  output logic irq_o
);
  if (NUM_MODULES != NUM_MOD) begin : g_check
    $error("cac_ctrl serves exactly six timer modules");
  end

  logic [7:0] ctrl;
  logic [7:0] status;
  logic [7:0] mode [NUM_MODULES];
  logic [7:0] cmp_lo [NUM_MODULES];
  logic [7:0] cmp_hi [NUM_MODULES];
  logic [7:0] rdata;
  logic irq;
  logic ext_prev;
  logic [7:0] next_ctrl;
  logic [7:0] next_status;
  logic [7:0] next_mode [NUM_MODULES];
  logic [7:0] next_cmp_lo [NUM_MODULES];
  logic [7:0] next_cmp_hi [NUM_MODULES];
  logic [7:0] next_rdata;
  logic next_irq;
  logic next_ext_prev;
  logic ext_sync;
  logic ext_edge;
  logic selected_tick;
  logic [7:0] hw_set;
  logic [7:0] sw_keep;
  logic [NUM_MODULES-1:0] mod_flags;
  logic [7:0] rd_val;
  logic wr_status;
  logic wr_ctrl;

  // External clock is only edge-detected, so it must stay below a quarter of clk_sys_i
  cac_sync #(.WIDTH(1)) u_ext_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(ext_clock_pin_i),
    .sync_o(ext_sync)
  );

  for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
    cac_mode_dec u_dec (
      .mode_i(mode[g]),
      .func_o(module_func_o[g])
    );
    assign compare_enable_o[g] = mode[g][MODE_COMP];
    assign module_irq_enable_o[g] = mode[g][MODE_IE];
    assign compare_value_o[g] = {cmp_hi[g], cmp_lo[g]};
  end

  assign wr_status = sfr_wr_i && (sfr_addr_i == ADDR_STATUS);
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_CTRL2);
  assign mod_flags = {status[6:4], status[2:0]};

  always_comb begin
    next_ext_prev = ext_sync;
    ext_edge = ext_sync && !ext_prev;
    selected_tick = 1'b0;
    if (clock_select_o == CLKSEL_PRESCALE) begin
      selected_tick = prescaler_tick_i;
    end else if (clock_select_o == CLKSEL_T0) begin
      selected_tick = timer0_overflow_i;
    end else if (clock_select_o == CLKSEL_EXT) begin
      selected_tick = ext_edge;
    end
  end

  assign counter_run_o = ctrl[CTRL_RUN];
  assign counter_advance_o = ctrl[CTRL_RUN] && !(ctrl[CTRL_IDLE] && cpu_idle_i);
  assign counter_tick_o = counter_advance_o && selected_tick;
  assign pwm_width_select_o = ctrl[CTRL_PWMW];
  assign clock_select_o = ctrl[CTRL_CLK_LSB +: 2];
  assign sfr_rdata_o = rdata;
  assign irq_o = irq;

  // Register writes and hardware flag updates
  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_cmp_lo = cmp_lo;
    next_cmp_hi = cmp_hi;
    if (wr_ctrl) begin
      next_ctrl = sfr_wdata_i & CTRL_MASK;
    end
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (sfr_wr_i && (sfr_addr_i == cac_reg_addr(ADDR_MODE_BASE, i))) begin
        next_mode[i] = sfr_wdata_i;
      end else if (sfr_wr_i && (sfr_addr_i == cac_reg_addr(ADDR_CMPL_BASE, i))) begin
        next_cmp_lo[i] = sfr_wdata_i;
        next_mode[i][MODE_COMP] = 1'b0;
      end else if (sfr_wr_i && (sfr_addr_i == cac_reg_addr(ADDR_CMPH_BASE, i))) begin
        next_cmp_hi[i] = sfr_wdata_i;
        next_mode[i][MODE_COMP] = 1'b1;
      end
    end
    // Overflow bits take the written value; module bits only clear on a written zero
    sw_keep = status;
    if (wr_status) begin
      sw_keep = (status & sfr_wdata_i & ST_MOD_MASK) | (sfr_wdata_i & ST_OVF_MASK);
    end
    hw_set = {second_overflow_event_i, module_event_i[5:3], first_overflow_event_i, module_event_i[2:0]};
    // A hardware event beats a clear in the same cycle
    next_status = sw_keep | hw_set;
  end

  // Read mux and interrupt combine
  always_comb begin
    rd_val = 8'h00;
    if (sfr_addr_i == ADDR_STATUS) begin
      rd_val = status;
    end else if (sfr_addr_i == ADDR_CTRL2) begin
      rd_val = ctrl & CTRL_MASK;
    end else begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (sfr_addr_i == cac_reg_addr(ADDR_MODE_BASE, i)) begin
          rd_val = mode[i];
        end else if (sfr_addr_i == cac_reg_addr(ADDR_CMPL_BASE, i)) begin
          rd_val = cmp_lo[i];
        end else if (sfr_addr_i == cac_reg_addr(ADDR_CMPH_BASE, i)) begin
          rd_val = cmp_hi[i];
        end
      end
    end
    next_rdata = sfr_rd_i ? rd_val : rdata;
    next_irq = (status[ST_OVF2] && ctrl[CTRL_OVF_IE]) || (status[ST_SECOND_OVERFLOW_FLAG] && first_overflow_irq_enable_i);
    for (int i = 0; i < NUM_MODULES; i++) begin
      next_irq = next_irq || (mod_flags[i] && mode[i][MODE_IE]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= CTRL_RESET;
      status <= ST_RESET;
      mode <= '{default: MODE_RESET};
      cmp_lo <= '{default: 8'h00};
      cmp_hi <= '{default: 8'h00};
      rdata <= 8'h00;
      irq <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      mode <= next_mode;
      cmp_lo <= next_cmp_lo;
      cmp_hi <= next_cmp_hi;
      rdata <= next_rdata;
      irq <= next_irq;
      ext_prev <= next_ext_prev;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_low_write;
    sfr_wr_i && (sfr_addr_i == ADDR_CMPL_BASE);
  endsequence

  sequence s_high_write;
    sfr_wr_i && (sfr_addr_i == ADDR_CMPH_BASE);
  endsequence

  // Module flags may stand, but both overflow flags are clear and no module interrupt is enabled
  sequence s_flag_no_enable;
    ((status & ST_OVF_MASK) == ST_RESET) && (module_irq_enable_o == '0);
  endsequence

  // Low byte clears the enable, then a high byte follows within a few cycles
  sequence s_low_then_high;
    s_low_write ##1 !compare_enable_o[0] ##[0:8] s_high_write;
  endsequence

  a_run_only_sw: assert property (!wr_ctrl |=> $stable(counter_run_o))
    else $error("Run bit changed without a control write");

  a_run_written: assert property (wr_ctrl |=> counter_run_o == $past(sfr_wdata_i[CTRL_RUN]))
    else $error("Run bit does not follow the control write");

  a_ovf_irq_raise: assert property (status[ST_OVF2] && ctrl[CTRL_OVF_IE] |=> irq_o)
    else $error("Second overflow with enable did not raise the request");

  a_idle_stop: assert property (ctrl[CTRL_IDLE] && cpu_idle_i |-> !counter_advance_o && !counter_tick_o)
    else $error("Counter advanced while halted in idle");

  a_idle_keep_run: assert property (ctrl[CTRL_RUN] && !ctrl[CTRL_IDLE] |-> counter_advance_o)
    else $error("Counter held while idle halt is off");

  a_width_select: assert property (wr_ctrl |=> pwm_width_select_o == $past(sfr_wdata_i[CTRL_PWMW]))
    else $error("Width select does not follow the control write");

  a_clock_source: assert property (counter_tick_o |-> counter_advance_o && (clock_select_o != 2'h3))
    else $error("Counter tick without a valid source or while held");

  a_prescale_tick: assert property (
    counter_advance_o && (clock_select_o == CLKSEL_PRESCALE) && prescaler_tick_i |-> counter_tick_o)
    else $error("Prescaler tick lost");

  a_ovf_set: assert property (
    (second_overflow_event_i |=> status[ST_OVF2]) and (first_overflow_event_i |=> status[ST_SECOND_OVERFLOW_FLAG]))
    else $error("Overflow event did not set its flag");

  // Without a same-cycle rollover the overflow bits take exactly what software wrote
  a_ovf_sw_set: assert property (
    wr_status && !second_overflow_event_i && !first_overflow_event_i
    |=> (status & ST_OVF_MASK) == ($past(sfr_wdata_i) & ST_OVF_MASK))
    else $error("Overflow flags do not follow the status write");

  a_flag_sticky: assert property (
    !wr_status |=> (status & $past(status) & ST_MOD_MASK) == ($past(status) & ST_MOD_MASK))
    else $error("Module flag cleared without a status write");

  a_flag_no_sw_set: assert property (
    wr_status && (module_event_i == 6'h00) |=> (status & ~$past(status) & ST_MOD_MASK) == 8'h00)
    else $error("Software write set a module flag");

  a_event_wins: assert property (module_event_i[0] && wr_status |=> status[0])
    else $error("Module event lost against a clear");

  a_irq_quiet: assert property ((status == ST_RESET) |=> !irq_o)
    else $error("Request raised with no flag set");

  a_irq_module: assert property (status[0] && mode[0][MODE_IE] |=> irq_o)
    else $error("Enabled module flag did not raise the request");

  a_second_overflow_flag_irq_raise: assert property (status[ST_SECOND_OVERFLOW_FLAG] && first_overflow_irq_enable_i |=> irq_o)
    else $error("First overflow with enable did not raise the request");

  a_irq_gate: assert property (s_flag_no_enable |=> !irq_o)
    else $error("Disabled module flag reached the request");

  a_mode_write: assert property (
    sfr_wr_i && (sfr_addr_i == ADDR_MODE_BASE)
    |=> module_irq_enable_o[0] == $past(sfr_wdata_i[MODE_IE])
        && compare_enable_o[0] == $past(sfr_wdata_i[MODE_COMP]))
    else $error("Mode register write not taken");

  a_mode_nop: assert property ((mode[0] == MODE_RESET) |-> module_func_o[0] == CAC_NOP)
    else $error("Zero mode not decoded as no operation");

  a_mode_toggle: assert property (((mode[0] & ~MODE_IE_MASK) == MODE_TOGGLE) |-> module_func_o[0] == CAC_TOGGLE)
    else $error("Toggle mode misdecoded");

  a_mode_pwm: assert property ((mode[0] == MODE_PWM8_PROG) |-> module_func_o[0] == CAC_PWM8_PROG)
    else $error("Programmable PWM mode misdecoded");

  a_mode_capture: assert property (
    ((mode[0] & ~MODE_COMP_MASK) == MODE_CAP_BOTH) |-> module_func_o[0] == CAC_CAP_BOTH)
    else $error("Either-edge capture misdecoded");

  a_cmp_sequence: assert property (s_low_then_high |=> compare_enable_o[0])
    else $error("Compare enable not cleared by low byte then set by high byte");

  a_cmp_low_clear: assert property (
    s_low_write |=> !compare_enable_o[0] && compare_value_o[0][7:0] == $past(sfr_wdata_i))
    else $error("Low byte write did not clear compare enable");
endmodule // cac_ctrl
`default_nettype wire

// file: rtl/cac_mode_dec.sv
// Purpose: Decodes one module mode byte into its operating function
// Assumes: Combinational, fed from the registered mode byte
// Notes: Combinations outside the known set decode as illegal
`timescale 1ns/1ns
`default_nettype none
module cac_mode_dec
  import cac_pkg::*;
(
  input wire logic [7:0] mode_i,
  output cac_func_t func_o
);
  logic [7:0] no_ie;
  logic [7:0] no_ie_comp;

  always_comb begin
    no_ie = mode_i & ~MODE_IE_MASK;
    no_ie_comp = no_ie & ~MODE_COMP_MASK;
    func_o = CAC_ILLEGAL;
    if (no_ie == MODE_RESET) begin
      func_o = CAC_NOP;
    end else if (no_ie == MODE_PWM8_FIX) begin
      func_o = CAC_PWM8_FIX;
    end else if (no_ie == MODE_PWM8_PROG) begin
      func_o = CAC_PWM8_PROG;
    end else if (no_ie == MODE_PWM_WIDE) begin
      func_o = CAC_PWM_WIDE;
    end else if (no_ie == MODE_TOGGLE) begin
      func_o = CAC_TOGGLE;
    end else if (no_ie == MODE_TIMER) begin
      func_o = CAC_TIMER;
    end else if (no_ie_comp == MODE_CAP_FALL) begin
      func_o = CAC_CAP_FALL;
    end else if (no_ie_comp == MODE_CAP_RISE) begin
      func_o = CAC_CAP_RISE;
    end else if (no_ie_comp == MODE_CAP_BOTH) begin
      func_o = CAC_CAP_BOTH;
    end
  end
endmodule // cac_mode_dec
`default_nettype wire

// file: rtl/cac_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Input level is stable for at least two clock periods
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module cac_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;
endmodule // cac_sync
`default_nettype wire

// file: shared/cac_pkg.sv
// Purpose: Shared constants and types for the counter array control and status block
// Assumes: 8-bit special-function register bus, byte-wide registers
// Notes: Mode and compare byte addresses are laid out as base plus module index
package cac_pkg;

  localparam int NUM_MOD = 6;

  // Register addresses
  localparam logic [7:0] ADDR_STATUS = 8'hA5;
  localparam logic [7:0] ADDR_CTRL2 = 8'hBC;
  localparam logic [7:0] ADDR_MODE_BASE = 8'hC0;
  localparam logic [7:0] ADDR_CMPL_BASE = 8'hC8;
  localparam logic [7:0] ADDR_CMPH_BASE = 8'hD0;

  // Second counter control fields
  localparam int CTRL_RUN = 6;
  localparam int CTRL_OVF_IE = 5;
  localparam int CTRL_IDLE = 4;
  localparam int CTRL_PWMW = 2;
  localparam int CTRL_CLK_LSB = 0;
  localparam logic [7:0] CTRL_MASK = 8'h77;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status fields
  localparam int ST_OVF2 = 7;
  localparam int ST_SECOND_OVERFLOW_FLAG = 3;
  localparam logic [7:0] ST_OVF_MASK = 8'h88;
  localparam logic [7:0] ST_MOD_MASK = 8'h77;
  localparam logic [7:0] ST_RESET = 8'h00;

  // Module mode fields
  localparam int MODE_IE = 7;
  localparam int MODE_COMP = 6;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_IE_MASK = 8'h80;
  localparam logic [7:0] MODE_COMP_MASK = 8'h40;
  localparam logic [7:0] MODE_PWM8_FIX = 8'h41;
  localparam logic [7:0] MODE_PWM8_PROG = 8'h42;
  localparam logic [7:0] MODE_PWM_WIDE = 8'h43;
  localparam logic [7:0] MODE_TOGGLE = 8'h4C;
  localparam logic [7:0] MODE_TIMER = 8'h48;
  localparam logic [7:0] MODE_CAP_FALL = 8'h10;
  localparam logic [7:0] MODE_CAP_RISE = 8'h20;
  localparam logic [7:0] MODE_CAP_BOTH = 8'h30;

  // Counter clock sources
  localparam logic [1:0] CLKSEL_PRESCALE = 2'h0;
  localparam logic [1:0] CLKSEL_T0 = 2'h1;
  localparam logic [1:0] CLKSEL_EXT = 2'h2;

  typedef enum logic [3:0] {
    CAC_NOP,
    CAC_PWM8_FIX,
    CAC_PWM8_PROG,
    CAC_PWM_WIDE,
    CAC_TOGGLE,
    CAC_TIMER,
    CAC_CAP_FALL,
    CAC_CAP_RISE,
    CAC_CAP_BOTH,
    CAC_ILLEGAL
  } cac_func_t;

  function automatic logic [7:0] cac_reg_addr(input logic [7:0] base, input int unsigned idx);
    return base + idx[7:0];
  endfunction

endpackage

// file: tb/cac_core_model.sv
// Purpose: Core-side model that issues special-function register accesses
// Assumes: One-cycle write and read strobes, read data taken a cycle after the read edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module cac_core_model (
  input wire logic clk_sys_i,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  input wire logic [7:0] sfr_rdata_i
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    sfr_wr_o = 1'b0;
    sfr_addr_o = ~a;
    sfr_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    sfr_addr_o = a;
    sfr_rd_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~a;
    @(posedge clk_sys_i);
    #1;
    d = sfr_rdata_i;
  endtask

  // Read the flags first, then clear only the serviced one; written 1s keep the others
  task automatic svc(input int bit_n, output logic [7:0] seen);
    rd(8'hA5, seen);
    wr(8'hA5, seen & ~(8'h01 << bit_n));
  endtask
endmodule // cac_core_model
`default_nettype wire

// file: tb/tb_counter_array_ctrl_status.sv
// Purpose: Self-checking bench for the counter array control and status block
// Assumes: Register accesses go through the core model tasks
// Notes: Waits after events cover the two-cycle path from event to interrupt
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_counter_array_ctrl_status;
  import cac_pkg::*;
  logic clk_sys, reset_n, cpu_idle, fo_ie, fo_ev, so_ev, pre, t0, ext;
  logic [5:0] mod_ev, comp_en, mod_ie;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, run, adv, tick, pwmw, irq, seen;
  logic [1:0] clk_sel;
  cac_func_t func [6];
  logic [15:0] cval [6];
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] mv [10] = '{8'h00, 8'h41, 8'h42, 8'h43, 8'hCC, 8'h48, 8'h10, 8'h20, 8'h70, 8'h80};
  cac_func_t ef [10] = '{CAC_NOP, CAC_PWM8_FIX, CAC_PWM8_PROG, CAC_PWM_WIDE, CAC_TOGGLE,
    CAC_TIMER, CAC_CAP_FALL, CAC_CAP_RISE, CAC_CAP_BOTH, CAC_NOP};

  cac_core_model i_core (.clk_sys_i(clk_sys), .sfr_addr_o(addr), .sfr_wdata_o(wdata),
    .sfr_wr_o(wr), .sfr_rd_o(rd), .sfr_rdata_i(rdata));
  cac_ctrl i_dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .cpu_idle_i(cpu_idle),
    .first_overflow_irq_enable_i(fo_ie), .first_overflow_event_i(fo_ev),
    .second_overflow_event_i(so_ev), .module_event_i(mod_ev), .prescaler_tick_i(pre),
    .timer0_overflow_i(t0), .ext_clock_pin_i(ext), .counter_run_o(run), .counter_advance_o(adv),
    .counter_tick_o(tick), .pwm_width_select_o(pwmw), .clock_select_o(clk_sel),
    .compare_enable_o(comp_en), .module_irq_enable_o(mod_ie), .module_func_o(func),
    .compare_value_o(cval), .irq_o(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Fires one source and reports whether any counter tick was seen within six cycles
  task automatic tick_try(input int src, output logic s);
    @(posedge clk_sys);
    #1;
    pre = (src == 0);
    t0 = (src == 1);
    ext = (src == 2);
    s = 1'b0;
    repeat (6) begin
      #2;
      s = s | tick;
      @(posedge clk_sys);
      #1;
      pre = 1'b0;
      t0 = 1'b0;
    end
    ext = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic pulse(input int which);
    @(posedge clk_sys);
    #1;
    if (which == 0) so_ev = 1'b1;
    else if (which == 1) fo_ev = 1'b1;
    else mod_ev = 6'h3F;
    @(posedge clk_sys);
    #1;
    so_ev = 1'b0;
    fo_ev = 1'b0;
    mod_ev = 6'h00;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    #50000;
    mismatches++;
    end_sim();
  end

  initial begin
    {reset_n, cpu_idle, fo_ie, fo_ev, so_ev, pre, t0, ext} = 8'h00;
    mod_ev = 6'h00;
    repeat (6) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    i_core.rd(ADDR_STATUS, d);
    `CHK("status reset", 8'h00, d)
    for (int m = 0; m < 6; m++) begin
      i_core.rd(ADDR_MODE_BASE + m[7:0], d);
      `CHK("mode reset", 8'h00, d)
      `CHK("func reset", CAC_NOP, func[m])
    end
    `CHK("irq reset", 1'b0, irq)
    i_core.wr(ADDR_CTRL2, 8'hFF);
    i_core.rd(ADDR_CTRL2, d);
    `CHK("ctrl reserved", 8'h77, d)
    i_core.wr(8'h00, 8'hFF);
    i_core.rd(8'h00, d);
    `CHK("unmapped", 8'h00, d)
    i_core.wr(ADDR_CTRL2, 8'h00);
    #1;
    `CHK("run off", 2'b00, {run, adv})
    i_core.wr(ADDR_CTRL2, 8'h50);
    cpu_idle = 1'b1;
    #1;
    `CHK("idle halt", 2'b10, {run, adv})
    tick_try(0, seen);
    `CHK("halted tick", 1'b0, seen)
    i_core.wr(ADDR_CTRL2, 8'h40);
    #1;
    `CHK("idle run", 1'b1, adv)
    cpu_idle = 1'b0;
    for (int s = 0; s < 4; s++) begin
      i_core.wr(ADDR_CTRL2, 8'h40 | s[7:0]);
      `CHK("clk sel", s[1:0], clk_sel)
      for (int src = 0; src < 3; src++) begin
        tick_try(src, seen);
        `CHK("tick source", (src == s), seen)
      end
    end
    i_core.wr(ADDR_CTRL2, 8'h20);
    pulse(0);
    `CHK("ovf2 irq", 1'b1, irq)
    i_core.svc(ST_OVF2, d);
    `CHK("ovf2 flag", 8'h80, d)
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("ovf2 cleared irq", 1'b0, irq)
    i_core.wr(ADDR_STATUS, 8'h80);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("sw set irq", 1'b1, irq)
    i_core.wr(ADDR_CTRL2, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("ovf2 masked", 1'b0, irq)
    i_core.wr(ADDR_STATUS, 8'h00);
    fo_ie = 1'b1;
    pulse(1);
    `CHK("second_overflow_flag irq", 1'b1, irq)
    i_core.rd(ADDR_STATUS, d);
    `CHK("second_overflow_flag flag", 8'h08, d)
    i_core.wr(ADDR_STATUS, 8'h00);
    pulse(2);
    `CHK("mod flags no ie", 1'b0, irq)
    i_core.wr(ADDR_STATUS, 8'h77);
    i_core.rd(ADDR_STATUS, d);
    `CHK("mod flags kept", 8'h77, d)
    i_core.wr(ADDR_MODE_BASE, MODE_IE_MASK);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("mod irq", 1'b1, irq)
    `CHK("mod ie", 6'h01, mod_ie)
    i_core.svc(0, d);
    i_core.rd(ADDR_STATUS, d);
    `CHK("mod0 cleared", 8'h76, d)
    `CHK("mod irq gone", 1'b0, irq)
    i_core.wr(ADDR_STATUS, 8'h00);
    // Event and clearing write meet at the same edge: the event must win
    fork
      i_core.wr(ADDR_STATUS, 8'h00);
      begin
        @(posedge clk_sys);
        #1;
        mod_ev = 6'h01;
        @(posedge clk_sys);
        #1;
        mod_ev = 6'h00;
      end
    join
    i_core.rd(ADDR_STATUS, d);
    `CHK("event beats clear", 8'h01, d)
    i_core.wr(ADDR_STATUS, 8'h00);
    for (int i = 0; i < 10; i++) begin
      i_core.wr(ADDR_MODE_BASE + 8'(i % 6), mv[i]);
      `CHK("func", ef[i], func[i % 6])
      i_core.rd(ADDR_MODE_BASE + 8'(i % 6), d);
      `CHK("mode rb", mv[i], d)
      i_core.wr(ADDR_MODE_BASE, mv[i]);
      `CHK("func0", ef[i], func[0])
    end
    i_core.wr(ADDR_MODE_BASE, 8'h0F);
    `CHK("func illegal", CAC_ILLEGAL, func[0])
    i_core.wr(ADDR_CTRL2, 8'h44);
    `CHK("pwm width", 1'b1, pwmw)
    for (int m = 0; m < 3; m++) i_core.wr(ADDR_MODE_BASE + m[7:0], MODE_PWM_WIDE);
    `CHK("wide pwm", 3'b111, {func[0] == CAC_PWM_WIDE, func[1] == CAC_PWM_WIDE, func[2] == CAC_PWM_WIDE})
    i_core.wr(ADDR_MODE_BASE, MODE_TIMER);
    i_core.wr(ADDR_CMPL_BASE, 8'h34);
    `CHK("low clears en", 1'b0, comp_en[0])
    i_core.rd(ADDR_MODE_BASE, d);
    `CHK("mode after low", 8'h08, d)
    i_core.wr(ADDR_CMPH_BASE, 8'h12);
    `CHK("high sets en", 1'b1, comp_en[0])
    `CHK("cmp value", 16'h1234, cval[0])
    end_sim();
  end
endmodule // tb_counter_array_ctrl_status
`default_nettype wire
